/* File: design/fpu_env_pkg.sv */
// Purpose: Shared constants and types for the floating-point environment state
// Assumes: Single 10 MHz core clock, commands arrive synchronous to it
// Notes: Control word reset image is the initialise value
`default_nettype none
package fpu_env_pkg;
  localparam int NUM_REGS = 8;
  localparam int OPC_W = 11;
  // ==========================================================
  // Control word layout
  localparam int MASK_LSB = 0;
  localparam int MASK_W = 6;
  localparam int PREC_LSB = 8;
  localparam int ROUND_LSB = 10;
  localparam logic [15:0] CW_INIT = 16'h037F;
  localparam logic [1:0] PREC_FULL = 2'h3;
  localparam logic [1:0] ROUND_NEAREST = 2'h0;
  localparam logic [1:0] ROUND_DOWN = 2'h1;
  localparam logic [1:0] ROUND_UP = 2'h2;
  localparam logic [1:0] ROUND_CHOP = 2'h3;
  // ==========================================================
  // Tag codes and status layout
  localparam logic [1:0] TAG_VALID = 2'h0;
  localparam logic [1:0] TAG_ZERO = 2'h1;
  localparam logic [1:0] TAG_SPECIAL = 2'h2;
  localparam logic [1:0] TAG_EMPTY = 2'h3;
  localparam int TOP_LSB = 11;
  localparam logic [2:0] TOP_INIT = 3'h0;
  localparam int SEG_SHIFT = 4;
  // ==========================================================
  // Commands and operation classes
  typedef enum logic [3:0] {
    no_op, initialise_unit_op, load_control_op, store_control_op, store_status_op,
    clear_exceptions_op, load_environment_op, store_environment_op, save_state_op,
    restore_state_op, push_op, pop_op, free_op
  } cmd_t;
  typedef enum logic [2:0] {
    class_precision_arith, class_other_arith, class_constant_load,
    class_store_memory, class_non_arith
  } op_class_t;
  typedef enum logic [1:0] {
    layout_prot32, layout_real32, layout_prot16, layout_real16
  } layout_t;
endpackage
`default_nettype wire

/* File: design/fpu_env_if.sv */
// Purpose: Carrier between the environment core and its helper modules
// Assumes: Combinational helpers, core registers every result
// Notes: Image words are always 32 bits, 16-bit layouts use low half
`timescale 1ns/1ps
`default_nettype none
interface fpu_env_if;
  logic [7:0] empty;
  logic [7:0] zero;
  logic [7:0] special;
  logic [15:0] tags;
  logic protected_mode;
  logic size32;
  logic [31:0] ip;
  logic [31:0] dp;
  logic [15:0] cs;
  logic [15:0] ds;
  logic [10:0] opcode;
  logic [3:0][31:0] image;
  modport tag_side (input empty, zero, special, output tags);
  modport ptr_side (input protected_mode, size32, ip, dp, cs, ds, opcode, output image);
  modport core (output empty, zero, special, protected_mode, size32, ip, dp, cs, ds,
    opcode, input tags, image);
endinterface
`default_nettype wire

/* File: design/tag_classifier.sv */
// Purpose: Full per-register tag classification from register contents
// Assumes: Zero and special flags come from the data register array
// Notes: Empty overrides every other class
`timescale 1ns/1ps
`default_nettype none
module tag_classifier
  import fpu_env_pkg::*;
(
  fpu_env_if.tag_side bus
);
  // ==========================================================
  // One two-bit field per physical register
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_tag
      assign bus.tags[2*g +: 2] = bus.empty[g] ? TAG_EMPTY :
                                  bus.special[g] ? TAG_SPECIAL :
                                  bus.zero[g] ? TAG_ZERO : TAG_VALID;
    end
  endgenerate
endmodule // tag_classifier
`default_nettype wire

/* File: design/pointer_image.sv */
// Purpose: Forms the four-word instruction and data pointer image
// Assumes: Real mode addresses are segment times sixteen plus offset
// Notes: Virtual-8086 callers must present protected_mode low
`timescale 1ns/1ps
`default_nettype none
module pointer_image
  import fpu_env_pkg::*;
(
  fpu_env_if.ptr_side bus
);
  // ==========================================================
  // Linear addresses for the real-mode layouts
  wire logic [31:0] lin_ip;
  wire logic [31:0] lin_dp;
  wire layout_t layout;
  assign lin_ip = {12'h000, bus.cs, 4'h0} + bus.ip;
  assign lin_dp = {12'h000, bus.ds, 4'h0} + bus.dp;
  assign layout = bus.protected_mode ? (bus.size32 ? layout_prot32 : layout_prot16)
                                     : (bus.size32 ? layout_real32 : layout_real16);
  always_comb begin
    case (layout)
      layout_prot32: begin
        bus.image[0] = bus.ip;
        bus.image[1] = {5'h00, bus.opcode, bus.cs};
        bus.image[2] = bus.dp;
        bus.image[3] = {16'h0000, bus.ds};
      end
      layout_real32: begin
        bus.image[0] = {16'h0000, lin_ip[15:0]};
        bus.image[1] = {4'h0, lin_ip[31:16], 1'b0, bus.opcode};
        bus.image[2] = {16'h0000, lin_dp[15:0]};
        bus.image[3] = {4'h0, lin_dp[31:16], 12'h000};
      end
      layout_prot16: begin
        bus.image[0] = {16'h0000, bus.ip[15:0]};
        bus.image[1] = {16'h0000, bus.cs};
        bus.image[2] = {16'h0000, bus.dp[15:0]};
        bus.image[3] = {16'h0000, bus.ds};
      end
      default: begin
        bus.image[0] = {16'h0000, lin_ip[15:0]};
        bus.image[1] = {16'h0000, lin_ip[19:16], 1'b0, bus.opcode};
        bus.image[2] = {16'h0000, lin_dp[15:0]};
        bus.image[3] = {16'h0000, lin_dp[19:16], 12'h000};
      end
    endcase
  end
endmodule // pointer_image
`default_nettype wire

/* File: design/fpu_env_state.sv */
// Purpose: Control word, tag word, pointers and last opcode of the FPU
// Assumes: One command per cycle, escape decode reported separately
// Notes: Status word carries only the stack-top field here
//
// Function
// [RL1] Control word bits 0 to 5 hold six exception mask bits.
// [RL2] Bits 8 and 9 select precision; default is 64-bit significand.
// [RL3] Precision only affects add, subtract, multiply, divide and square root.
// [RL4] Bits 10 and 11 select nearest, directed or chop rounding.
// [RL5] Rounding applies to arithmetic, constant loads and stores to memory.
// [RL6] Tags: 00 valid, 01 zero, 10 special, 11 empty.
// [RL7] Tag entries follow physical register number, not stack position.
// [RL8] Full tags computed only on environment store or save.
// [RL9] Each escape decode records instruction address, operand address, opcode; code skips control escapes.
// [RL10] Pointer image has four layouts by mode and operand size.
// [RL11] Saved instruction address points at the first prefix byte.
// [RL12] Control-class instructions leave the data pointer unchanged.
// [RL13] Otherwise data pointer may be stale without a memory operand.
// [RL14] Keep 11-bit opcode of last non-control instruction.
// [RL15] Opcode drops the five common upper bits; second byte is low.
// [RL16] Status word bits 11 to 13 hold the stack-top pointer.
// [RL17] Rounding codes: nearest, down, up, chop toward zero.
`timescale 1ns/1ps
`default_nettype none
module fpu_env_state
  import fpu_env_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic cmd_valid_i,
  input wire cmd_t cmd_i,
  input wire logic [15:0] mem_data_i,
  input wire logic [15:0] env_tags_i,
  input wire logic [2:0] free_reg_i,
  input wire logic esc_valid_i,
  input wire logic esc_control_i,
  input wire logic esc_has_mem_i,
  input wire logic [31:0] esc_addr_i,
  input wire logic [3:0] prefix_count_i,
  input wire logic [31:0] operand_addr_i,
  input wire logic [15:0] code_sel_i,
  input wire logic [15:0] data_sel_i,
  input wire logic [7:0] first_byte_i,
  input wire logic [7:0] second_byte_i,
  input wire logic protected_mode_i,
  input wire logic operand_32_i,
  input wire logic [7:0] reg_zero_i,
  input wire logic [7:0] reg_special_i,
  input wire op_class_t op_class_i,
  output logic [15:0] fp_control_word_o,
  output logic [5:0] exception_masks_o,
  output logic [15:0] fp_register_tags_o,
  output logic [7:0] reg_empty_o,
  output logic [10:0] last_fp_opcode_o,
  output logic [15:0] status_word_o,
  output logic [15:0] stored_word_o,
  output logic [127:0] env_image_o,
  output logic env_valid_o,
  output logic [1:0] precision_o,
  output logic [1:0] rounding_o,
  output logic round_apply_o
);
  // ==========================================================
  // State
  logic [15:0] cw;
  logic [7:0] empty;
  logic [2:0] top;
  logic [31:0] ip;
  logic [31:0] dp;
  logic [15:0] cs;
  logic [15:0] ds;
  logic [10:0] opcode;
  fpu_env_if env ();

  // ==========================================================
  // Command decode
  wire logic is_init;
  wire logic is_load_cw;
  wire logic is_load_env;
  wire logic is_store_env;
  wire logic is_push;
  wire logic is_pop;
  wire logic is_free;
  wire logic is_store_word;
  wire logic esc_data;
  wire logic esc_record;
  wire logic [2:0] top_dec;
  wire logic [7:0] env_empty;
  wire logic [7:0] next_empty;
  wire logic [15:0] next_cw;
  wire logic [15:0] status_img;
  assign is_init = cmd_valid_i && cmd_i == initialise_unit_op;
  assign is_load_cw = cmd_valid_i && cmd_i == load_control_op;
  assign is_load_env = cmd_valid_i &&
                       (cmd_i == load_environment_op || cmd_i == restore_state_op);
  assign is_store_env = cmd_valid_i &&
                        (cmd_i == store_environment_op || cmd_i == save_state_op);
  assign is_push = cmd_valid_i && cmd_i == push_op;
  assign is_pop = cmd_valid_i && cmd_i == pop_op;
  assign is_free = cmd_valid_i && cmd_i == free_op;
  assign is_store_word = cmd_valid_i &&
                         (cmd_i == store_control_op || cmd_i == store_status_op);
  assign top_dec = top - 3'h1;
  // Control-class escapes never touch the pointers or opcode
  assign esc_record = esc_valid_i && !esc_control_i; // RL9 RL14
  assign esc_data = esc_record && esc_has_mem_i; // RL12 RL13
  assign status_img = {2'h0, top, 11'h000}; // RL16

  // ==========================================================
  // Control word next value
  assign next_cw = is_init ? CW_INIT :
                   (is_load_cw || is_load_env) ? mem_data_i : cw; // RL1 RL2 RL4

  // ==========================================================
  // Per-register empty tracking, one generate loop
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_empty
      assign env_empty[g] = env_tags_i[2*g +: 2] == TAG_EMPTY; // RL6 RL7
      assign next_empty[g] = is_init ? 1'b1 :
                             is_load_env ? env_empty[g] :
                             (is_push && top_dec == g) ? 1'b0 :
                             (is_pop && top == g) ? 1'b1 :
                             (is_free && free_reg_i == g) ? 1'b1 : empty[g]; // RL8
    end
  endgenerate

  // ==========================================================
  // Helpers: full classification and pointer image
  assign env.empty = empty;
  assign env.zero = reg_zero_i;
  assign env.special = reg_special_i;
  assign env.protected_mode = protected_mode_i; // RL10
  assign env.size32 = operand_32_i;
  assign env.ip = ip;
  assign env.dp = dp;
  assign env.cs = cs;
  assign env.ds = ds;
  assign env.opcode = opcode;
  tag_classifier u_tags (
    .bus(env.tag_side)
  );
  pointer_image u_image (
    .bus(env.ptr_side)
  );

  // ==========================================================
  // Architectural registers
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cw <= CW_INIT;
      empty <= 8'hFF;
      top <= TOP_INIT;
    end else begin
      cw <= next_cw;
      empty <= next_empty;
      if (is_init) begin
        top <= TOP_INIT;
      end else if (is_push) begin
        top <= top_dec; // RL16
      end else if (is_pop) begin
        top <= top + 3'h1;
      end
    end
  end

  // Pointers and opcode cleared on reset; software reads them only after an escape
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ip <= 32'h0000_0000;
      cs <= 16'h0000;
      opcode <= 11'h000;
    end else if (esc_record) begin
      ip <= esc_addr_i - {28'h000_0000, prefix_count_i}; // RL9 RL11
      cs <= code_sel_i;
      opcode <= {first_byte_i[2:0], second_byte_i}; // RL14 RL15
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dp <= 32'h0000_0000;
      ds <= 16'h0000;
    end else if (esc_data) begin
      dp <= operand_addr_i; // RL9 RL12
      ds <= data_sel_i;
    end
  end

  // ==========================================================
  // Stored images: tags classified only here
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fp_register_tags_o <= 16'hFFFF;
      env_image_o <= 128'h0;
      env_valid_o <= 1'b0;
      stored_word_o <= 16'h0000;
    end else begin
      env_valid_o <= is_store_env;
      if (is_store_env) begin
        fp_register_tags_o <= env.tags; // RL8
        env_image_o <= env.image; // RL10
      end else if (is_init) begin
        fp_register_tags_o <= 16'hFFFF;
      end else if (is_load_env) begin
        fp_register_tags_o <= env_tags_i;
      end
      if (is_store_word) begin
        stored_word_o <= (cmd_i == store_control_op) ? cw : status_img;
      end
    end
  end

  // ==========================================================
  // Effective precision and rounding for the operation in flight
  wire logic prec_used;
  wire logic round_used;
  assign prec_used = op_class_i == class_precision_arith; // RL3
  assign round_used = op_class_i != class_non_arith; // RL5
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      precision_o <= PREC_FULL;
      rounding_o <= ROUND_NEAREST;
      round_apply_o <= 1'b0;
    end else begin
      precision_o <= prec_used ? cw[PREC_LSB +: 2] : PREC_FULL; // RL2 RL3
      // Unused rounding falls back to nearest so datapaths see a known code
      rounding_o <= round_used ? cw[ROUND_LSB +: 2] : ROUND_NEAREST; // RL4 RL17
      round_apply_o <= round_used;
    end
  end

  assign fp_control_word_o = cw;
  assign exception_masks_o = cw[MASK_LSB +: MASK_W];
  assign reg_empty_o = empty;
  assign last_fp_opcode_o = opcode;
  assign status_word_o = status_img;

  // ==========================================================
  // Checks
  sequence s_store;
    is_store_env;
  endsequence
  sequence s_push_pop;
    is_push ##2 is_pop;
  endsequence

  a_mask_load: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL1
    is_load_cw |=> exception_masks_o == $past(mem_data_i[5:0]))
    else $error("mask bits not loaded");
  a_prec_init: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL2
    is_init |=> cw[PREC_LSB +: 2] == PREC_FULL)
    else $error("initialise did not select full precision");
  a_prec_scope: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL3
    !prec_used |=> precision_o == PREC_FULL)
    else $error("precision applied outside its operations");
  a_round_field: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL4
    round_used && !is_load_cw && !is_load_env && !is_init
    |=> rounding_o == cw[ROUND_LSB +: 2])
    else $error("rounding field not forwarded");
  a_round_scope: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL5
    op_class_i == class_non_arith |=> !round_apply_o && rounding_o == ROUND_NEAREST)
    else $error("rounding applied to non-arithmetic operation");
  a_tag_empty: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL6
    s_store and empty[0] |=> fp_register_tags_o[1:0] == TAG_EMPTY && env_valid_o)
    else $error("empty register not tagged empty");
  a_tag_physical: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL7
    s_store and !empty[5] and reg_zero_i[5] and !reg_special_i[5]
    |=> fp_register_tags_o[11:10] == TAG_ZERO)
    else $error("tag not placed by physical register");
  a_tag_hold: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL8
    !is_store_env && !is_init && !is_load_env |=> $stable(fp_register_tags_o))
    else $error("tag image changed outside store");
  a_ptr_prefix: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL11
    esc_record |=> ip == $past(esc_addr_i) - {28'h000_0000, $past(prefix_count_i)})
    else $error("instruction address not at first prefix");
  a_dp_keep: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL12
    esc_valid_i && esc_control_i |=> $stable(dp) && $stable(ds))
    else $error("control escape changed data pointer");
  a_opcode_form: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL15
    esc_record |=> last_fp_opcode_o == {$past(first_byte_i[2:0]), $past(second_byte_i)})
    else $error("opcode field malformed");
  a_layout_prot: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL10
    s_store and protected_mode_i and operand_32_i
    |=> env_image_o[31:0] == $past(ip) && env_image_o[47:32] == $past(cs))
    else $error("protected 32-bit image wrong");
  a_top_walk: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL16
    s_push_pop |=> status_word_o[TOP_LSB +: 3] == $past(top, 3))
    else $error("stack top not restored by push then pop");
  // Live empty bits track push and pop, never the full classification
  a_push_full: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL8
    is_push |=> !empty[$past(top_dec)])
    else $error("push did not mark register non-empty");
  a_pop_empty: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL8
    is_pop |=> empty[$past(top)])
    else $error("pop did not mark register empty");
  a_init_tags: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL6
    is_init |=> fp_register_tags_o == 16'hFFFF && reg_empty_o == 8'hFF)
    else $error("initialise did not empty every register");
  a_env_pulse: assert property (@(posedge clock_i) disable iff (!resetn_i) // RL8
    !is_store_env |=> !env_valid_o)
    else $error("image valid without store");
endmodule // fpu_env_state
`default_nettype wire

/* File: tb/fpu_env_state_tb.sv */
// Purpose: Self-checking bench for the floating-point environment state block
// Assumes: Commands and escapes driven on rising clock_i by non-blocking assignment
// Notes: Each command takes two cycles here, so results are sampled after the taking edge
`timescale 1ns/1ps
`default_nettype none
module fpu_env_state_tb;
  import fpu_env_pkg::*;
  // ==========================================================
  // Signals
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  cmd_t cmd_i = no_op;
  logic [15:0] mem_data_i = 16'h0000;
  logic [15:0] env_tags_i = 16'h0000;
  logic [2:0] free_reg_i = 3'h0;
  logic esc_valid_i = 1'b0;
  logic esc_control_i = 1'b0;
  logic esc_has_mem_i = 1'b0;
  logic [31:0] esc_addr_i = 32'h0;
  logic [3:0] prefix_count_i = 4'h0;
  logic [31:0] operand_addr_i = 32'h0;
  logic [15:0] code_sel_i = 16'h0;
  logic [15:0] data_sel_i = 16'h0;
  logic [7:0] first_byte_i = 8'h00;
  logic [7:0] second_byte_i = 8'h00;
  logic protected_mode_i = 1'b1;
  logic operand_32_i = 1'b1;
  logic [7:0] reg_zero_i = 8'h00;
  logic [7:0] reg_special_i = 8'h00;
  op_class_t op_class_i = class_non_arith;
  logic [15:0] fp_control_word_o;
  logic [5:0] exception_masks_o;
  logic [15:0] fp_register_tags_o;
  logic [7:0] reg_empty_o;
  logic [10:0] last_fp_opcode_o;
  logic [15:0] status_word_o;
  logic [15:0] stored_word_o;
  logic [127:0] env_image_o;
  logic env_valid_o;
  logic [1:0] precision_o;
  logic [1:0] rounding_o;
  logic round_apply_o;
  int err_count = 0;
  int check_count = 0;
  int cycle_count = 0;
  cmd_t ctl_cmds [9] = '{initialise_unit_op, load_control_op, store_control_op,
    store_status_op, clear_exceptions_op, load_environment_op, store_environment_op,
    save_state_op, restore_state_op};
  op_class_t oc;
  logic [15:0] cw;

  fpu_env_state i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i), .mem_data_i(mem_data_i), .env_tags_i(env_tags_i),
    .free_reg_i(free_reg_i), .esc_valid_i(esc_valid_i), .esc_control_i(esc_control_i),
    .esc_has_mem_i(esc_has_mem_i), .esc_addr_i(esc_addr_i),
    .prefix_count_i(prefix_count_i), .operand_addr_i(operand_addr_i),
    .code_sel_i(code_sel_i), .data_sel_i(data_sel_i), .first_byte_i(first_byte_i),
    .second_byte_i(second_byte_i), .protected_mode_i(protected_mode_i),
    .operand_32_i(operand_32_i), .reg_zero_i(reg_zero_i), .reg_special_i(reg_special_i),
    .op_class_i(op_class_i), .fp_control_word_o(fp_control_word_o),
    .exception_masks_o(exception_masks_o), .fp_register_tags_o(fp_register_tags_o),
    .reg_empty_o(reg_empty_o), .last_fp_opcode_o(last_fp_opcode_o),
    .status_word_o(status_word_o), .stored_word_o(stored_word_o),
    .env_image_o(env_image_o), .env_valid_o(env_valid_o), .precision_o(precision_o),
    .rounding_o(rounding_o), .round_apply_o(round_apply_o));

  // ==========================================================
  // Clock and watchdog
  always #50 clock_i = ~clock_i;

  // Whole run needs about 110 cycles; ceiling leaves wide margin
  always @(posedge clock_i) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 3000) begin
      err_count++;
      end_of_test();
    end
  end

  // ==========================================================
  // Tasks
  task automatic end_of_test();
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_flag(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic do_cmd(input cmd_t c, input logic [15:0] md, input logic [15:0] tg);
    @(posedge clock_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= c;
    mem_data_i <= md;
    env_tags_i <= tg;
    @(posedge clock_i);
    cmd_valid_i <= 1'b0;
    cmd_i <= no_op;
    #1;
  endtask

  task automatic do_esc(input logic ctl, input logic mem, input logic [31:0] a,
    input logic [3:0] pc, input logic [31:0] oa, input logic [15:0] cs,
    input logic [15:0] ds, input logic [7:0] b1, input logic [7:0] b2);
    @(posedge clock_i);
    esc_valid_i <= 1'b1;
    esc_control_i <= ctl;
    esc_has_mem_i <= mem;
    esc_addr_i <= a;
    prefix_count_i <= pc;
    operand_addr_i <= oa;
    code_sel_i <= cs;
    data_sel_i <= ds;
    first_byte_i <= b1;
    second_byte_i <= b2;
    @(posedge clock_i);
    esc_valid_i <= 1'b0;
    #1;
  endtask

  // Low-half compare only for 16-bit layouts, upper half is unused there
  task automatic check_image(input logic [3:0][31:0] exp, input logic half);
    logic [31:0] m;
    m = half ? 32'h0000FFFF : 32'hFFFFFFFF;
    for (int k = 0; k < 4; k++) begin
      check_val("image word", exp[k] & m, env_image_o[32*k +: 32] & m);
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    #1;
    check_val("cw reset", 32'h037F, fp_control_word_o);
    check_val("masks reset", 32'h3F, exception_masks_o);
    check_val("tags reset", 32'hFFFF, fp_register_tags_o);
    check_val("precision reset", 32'h3, precision_o);
    check_val("opcode reset", 32'h0, last_fp_opcode_o);
    // Every rounding code against every operation class
    for (int r = 0; r < 4; r++) begin
      cw = {4'h0, r[1:0], 2'h2, 2'h0, 6'h2A};
      do_cmd(load_control_op, cw, 16'h0000);
      check_val("cw load", cw, fp_control_word_o);
      check_val("masks", 32'h2A, exception_masks_o);
      for (int c = 0; c < 5; c++) begin
        oc = op_class_t'(c);
        @(posedge clock_i);
        op_class_i <= oc;
        @(posedge clock_i);
        #1;
        check_val("precision", (oc == class_precision_arith) ? 2'h2 : 2'h3, precision_o);
        check_val("rounding", (oc == class_non_arith) ? 2'h0 : r[1:0], rounding_o);
        check_flag("round apply", oc != class_non_arith, round_apply_o);
      end
    end
    // Escape capture and protected 32-bit image
    do_esc(1'b0, 1'b1, 32'h100, 4'h2, 32'h2000, 16'h0010, 16'h0020, 8'hD9, 8'hC0);
    check_val("opcode", 32'h1C0, last_fp_opcode_o);
    do_cmd(store_environment_op, 16'h0000, 16'h0000);
    check_flag("env valid", 1'b1, env_valid_o);
    check_image('{32'h20, 32'h2000, {5'h0, 11'h1C0, 16'h10}, 32'hFE}, 1'b0);
    @(posedge clock_i);
    #1;
    check_flag("env valid drop", 1'b0, env_valid_o);
    // Control escape and control commands keep pointers
    do_esc(1'b1, 1'b1, 32'h500, 4'h0, 32'h3000, 16'h0011, 16'h0022, 8'hDB, 8'hE3);
    check_val("opcode ctl esc", 32'h1C0, last_fp_opcode_o);
    foreach (ctl_cmds[k]) begin
      do_cmd(ctl_cmds[k], CW_INIT, 16'hFFFF);
    end
    check_image('{32'h20, 32'h2000, {5'h0, 11'h1C0, 16'h10}, 32'hFE}, 1'b0);
    // No memory operand, then real 16-bit image
    do_esc(1'b0, 1'b0, 32'h200, 4'h0, 32'h4444, 16'h0010, 16'h0033, 8'hDD, 8'hD8);
    check_val("opcode no mem", 32'h5D8, last_fp_opcode_o);
    @(posedge clock_i);
    protected_mode_i <= 1'b0;
    operand_32_i <= 1'b0;
    do_cmd(store_environment_op, 16'h0000, 16'h0000);
    check_image('{32'h0, 32'h2200, 32'h05D8, 32'h0300}, 1'b1);
    // Tags by physical register, classified only on store
    do_cmd(initialise_unit_op, 16'h0000, 16'h0000);
    check_val("cw init", 32'h037F, fp_control_word_o);
    for (int k = 0; k < 3; k++) begin
      do_cmd(push_op, 16'h0000, 16'h0000);
    end
    check_val("status top", 32'h2800, status_word_o);
    check_val("empty bits", 32'h1F, reg_empty_o);
    @(posedge clock_i);
    reg_zero_i <= 8'hA1;
    reg_special_i <= 8'h42;
    do_cmd(store_environment_op, 16'h0000, 16'h0000);
    check_val("tags classified", 32'h67FF, fp_register_tags_o);
    @(posedge clock_i);
    free_reg_i <= 3'h7;
    do_cmd(free_op, 16'h0000, 16'h0000);
    check_val("empty after free", 32'h9F, reg_empty_o);
    check_val("tags held", 32'h67FF, fp_register_tags_o);
    do_cmd(store_status_op, 16'h0000, 16'h0000);
    check_val("stored status", 32'h2800, stored_word_o);
    do_cmd(store_control_op, 16'h0000, 16'h0000);
    check_val("stored cw", 32'h037F, stored_word_o);
    do_cmd(push_op, 16'h0000, 16'h0000);
    check_val("empty after push", 32'h8F, reg_empty_o);
    do_cmd(pop_op, 16'h0000, 16'h0000);
    check_val("status after pop", 32'h2800, status_word_o);
    check_val("empty after pop", 32'h9F, reg_empty_o);
    do_cmd(load_environment_op, 16'h0C7F, 16'h5A5A);
    check_val("cw env load", 32'h0C7F, fp_control_word_o);
    check_val("tags env load", 32'h5A5A, fp_register_tags_o);
    end_of_test();
  end
endmodule // fpu_env_state_tb
`default_nettype wire
